// *** rtl/sledfi_consts.vh ***
`ifndef SLEDFI_CONSTS_VH
`define SLEDFI_CONSTS_VH

// Clock cycles in one millisecond at 40 MHz
`define SLEDFI_CYC_PER_MS 40000

// Durations in milliseconds
`define SLEDFI_FLASH_ON_MS 200
`define SLEDFI_FLASH_OFF_MS 300
`define SLEDFI_GAP_MS 1500
`define SLEDFI_SLOW_HALF_MS 500
`define SLEDFI_BLINK_MS 50
`define SLEDFI_ACT_WIN_MS 250
`define SLEDFI_DMX_LOSS_MS 1000
`define SLEDFI_MOTOR_HOLD_MS 2000

// Register byte offsets
`define SLEDFI_ADDR_CTRL 8'h00
`define SLEDFI_ADDR_PROD 8'h04
`define SLEDFI_ADDR_FAULT 8'h08
`define SLEDFI_ADDR_STATUS 8'h0C

// Field positions and reset values
`define SLEDFI_CTRL_DMX_BIT 0
`define SLEDFI_CTRL_RESET 1'b0
`define SLEDFI_PROD_TYPE_LSB 0
`define SLEDFI_PROD_MASK_LSB 8
`define SLEDFI_PROD_TYPE_RESET 4'h0
`define SLEDFI_PROD_MASK_RESET 4'hF
`define SLEDFI_PROD_TYPE_MAX 4'h6

// Fault bit positions; the flash count is the position plus one
`define SLEDFI_F_PAN_LIM 0
`define SLEDFI_F_TILT_LIM 1
`define SLEDFI_F_PAN_OC 2
`define SLEDFI_F_TILT_OC 3
`define SLEDFI_F_FOCUS_OC 4
`define SLEDFI_F_PANEL_OC 5
`define SLEDFI_F_HEATER_OC 6
`define SLEDFI_F_LIM_ERR 7
`define SLEDFI_F_DATUM 8
`define SLEDFI_F_PROD 9
`define SLEDFI_F_SUPPLY 10
`define SLEDFI_NUM_FAULTS 11

// Default software version flashed at power-up
`define SLEDFI_SW_VERSION 4'h3

`endif

// *** rtl/sledfi_burst.v ***
`include "sledfi_consts.vh"

// Emits a burst of count_in equal flashes, then a one-cycle done pulse
module sledfi_burst #(
	parameter [31:0] ON_CYC = `SLEDFI_FLASH_ON_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] OFF_CYC = `SLEDFI_FLASH_OFF_MS * `SLEDFI_CYC_PER_MS
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire start_in,
	input wire [3:0] count_in,
	output reg led_out,
	output reg done_out
);

reg running_reg;
reg phase_on_reg;
reg [3:0] left_reg;
reg [31:0] tmr_reg;

always @(posedge ref_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		running_reg <= 1'b0;
		phase_on_reg <= 1'b0;
		left_reg <= 4'h0;
		tmr_reg <= 32'h0;
		led_out <= 1'b0;
		done_out <= 1'b0;
	end
	else
	begin
		done_out <= 1'b0;
		if (start_in)
		begin
			// A zero count finishes at once with no flash
			running_reg <= (count_in != 4'h0);
			done_out <= (count_in == 4'h0);
			phase_on_reg <= 1'b1;
			left_reg <= count_in;
			tmr_reg <= ON_CYC - 32'h1;
			led_out <= (count_in != 4'h0);
		end
		else if (running_reg)
		begin
			if (tmr_reg != 32'h0)
				tmr_reg <= tmr_reg - 32'h1;
			else if (phase_on_reg)
			begin
				phase_on_reg <= 1'b0;
				led_out <= 1'b0;
				left_reg <= left_reg - 4'h1;
				tmr_reg <= OFF_CYC - 32'h1;
			end
			else if (left_reg == 4'h0)
			begin
				running_reg <= 1'b0;
				done_out <= 1'b1;
			end
			else
			begin
				phase_on_reg <= 1'b1;
				led_out <= 1'b1;
				tmr_reg <= ON_CYC - 32'h1;
			end
		end
	end
end

endmodule

// *** rtl/sledfi_top.v ***
// Operation
// - At power-up flash green as many times as the software version.
// - Bus mode without fault: steady green.
// - Each valid bus reception blanks green briefly.
// - Continuous bus data makes green flash slowly.
// - DMX mode with data present: slow green flash.
// - DMX mode without data: steady green.
// - Any active fault removes green after the version burst; only red fault bursts show.
// - Each fault flashes red as many times as its code.
// - Several faults show one after another with a pause between bursts.
// - Either pan limit switch gives code one, even at normal travel end.
// - Either tilt limit switch gives code two, even at normal travel end.
// - Pan overcurrent stops pan drive for a while; code three latched.
// - Tilt overcurrent stops tilt drive for a while; indication latched.
// - Focus overcurrent stops focus drive for a while; code five latched.
// - Panel supply overcurrent switches that output off until power cycle.
// - Heater overcurrent switches heater off until power cycle.
// - Limit switch unused by product type gives code eight.
// - Failed start-up datum sequence gives code nine.
// - Unset, invalid or corrupt product type gives code ten.
// - Supply out of window gives code eleven.
`include "sledfi_consts.vh"

module sledfi_top #(
	parameter [3:0] SW_VERSION = `SLEDFI_SW_VERSION,
	parameter [31:0] ON_CYC = `SLEDFI_FLASH_ON_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] OFF_CYC = `SLEDFI_FLASH_OFF_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] GAP_CYC = `SLEDFI_GAP_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] SLOW_CYC = `SLEDFI_SLOW_HALF_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] BLINK_CYC = `SLEDFI_BLINK_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] ACT_CYC = `SLEDFI_ACT_WIN_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] DMX_CYC = `SLEDFI_DMX_LOSS_MS * `SLEDFI_CYC_PER_MS,
	parameter [31:0] HOLD_CYC = `SLEDFI_MOTOR_HOLD_MS * `SLEDFI_CYC_PER_MS
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output reg hreadyout_out,
	output reg hresp_out,
	input wire [1:0] pan_lim_in,
	input wire [1:0] tilt_lim_in,
	input wire pan_oc_in,
	input wire tilt_oc_in,
	input wire focus_oc_in,
	input wire panel_oc_in,
	input wire heater_oc_in,
	input wire datum_err_in,
	input wire supply_bad_in,
	input wire bus_rx_valid_in,
	input wire dmx_rx_valid_in,
	output reg led_green_out,
	output reg led_red_out,
	output reg pan_drv_en_out,
	output reg tilt_drv_en_out,
	output reg focus_drv_en_out,
	output reg panel_pwr_en_out,
	output reg heater_en_out
);

localparam [4:0] ST_VER = 5'h01;
localparam [4:0] ST_NORM = 5'h02;
localparam [4:0] ST_PICK = 5'h04;
localparam [4:0] ST_RUN = 5'h08;
localparam [4:0] ST_GAP = 5'h10;
localparam NF = `SLEDFI_NUM_FAULTS;

// Bus slave
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg dmx_mode_reg;
reg [3:0] prod_type_reg;
reg [3:0] lim_use_reg;
reg [31:0] rd_next;

// Fault and drive state
reg [4:0] oc_latch_reg;
reg [31:0] pan_hold_reg;
reg [31:0] tilt_hold_reg;
reg [31:0] focus_hold_reg;
wire [NF-1:0] faults;
wire any_fault;

// Indication state
reg [4:0] state_reg;
reg [4:0] state_next;
reg [3:0] cur_reg;
reg [3:0] cur_next;
reg burst_start_reg;
reg burst_start_next;
reg [3:0] burst_cnt_reg;
reg [3:0] burst_cnt_next;
reg [31:0] gap_reg;
reg [31:0] gap_next;
reg [31:0] slow_reg;
reg slow_phase_reg;
reg [31:0] blink_reg;
reg [31:0] act_reg;
reg bus_cont_reg;
reg [31:0] dmx_reg;
reg green_next;
reg red_next;
wire burst_led;
wire burst_done;

// Next fault search
reg [3:0] sel_code;
reg hit_above;
reg hit_any;
reg [3:0] low_code;
reg [3:0] above_code;
integer i;

wire addr_phase = hsel_in & hready_in & htrans_in[1];
wire [7:0] rd_addr = haddr_in[7:0];

always @*
begin
	rd_next = 32'h0;
	case (rd_addr)
		`SLEDFI_ADDR_CTRL: rd_next[`SLEDFI_CTRL_DMX_BIT] = dmx_mode_reg;
		`SLEDFI_ADDR_PROD:
		begin
			rd_next[`SLEDFI_PROD_TYPE_LSB +: 4] = prod_type_reg;
			rd_next[`SLEDFI_PROD_MASK_LSB +: 4] = lim_use_reg;
		end
		`SLEDFI_ADDR_FAULT: rd_next[NF-1:0] = faults;
		`SLEDFI_ADDR_STATUS:
		begin
			rd_next[4:0] = state_reg;
			rd_next[5] = led_green_out;
			rd_next[6] = led_red_out;
			rd_next[7] = pan_drv_en_out;
			rd_next[8] = tilt_drv_en_out;
			rd_next[9] = focus_drv_en_out;
			rd_next[10] = panel_pwr_en_out;
			rd_next[11] = heater_en_out;
			rd_next[15:12] = cur_reg;
			rd_next[19:16] = SW_VERSION;
		end
		default: rd_next = 32'h0;
	endcase
end

// Zero wait state: read data are registered during the address phase
always @(posedge ref_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= 8'h00;
		hrdata_out <= 32'h0;
		hreadyout_out <= 1'b1;
		hresp_out <= 1'b0;
		dmx_mode_reg <= `SLEDFI_CTRL_RESET;
		prod_type_reg <= `SLEDFI_PROD_TYPE_RESET;
		lim_use_reg <= `SLEDFI_PROD_MASK_RESET;
	end
	else
	begin
		hreadyout_out <= 1'b1;
		hresp_out <= 1'b0;
		wr_pend_reg <= addr_phase & hwrite_in;
		if (addr_phase)
			wr_addr_reg <= rd_addr;
		if (addr_phase & ~hwrite_in)
			hrdata_out <= rd_next;
		if (wr_pend_reg)
		begin
			case (wr_addr_reg)
				`SLEDFI_ADDR_CTRL: dmx_mode_reg <= hwdata_in[`SLEDFI_CTRL_DMX_BIT];
				`SLEDFI_ADDR_PROD:
				begin
					prod_type_reg <= hwdata_in[`SLEDFI_PROD_TYPE_LSB +: 4];
					lim_use_reg <= hwdata_in[`SLEDFI_PROD_MASK_LSB +: 4];
				end
				default: dmx_mode_reg <= dmx_mode_reg;
			endcase
		end
	end
end

// Limit switches show as plain levels, so they also flash at normal travel end
assign faults[`SLEDFI_F_PAN_LIM] = |pan_lim_in;
assign faults[`SLEDFI_F_TILT_LIM] = |tilt_lim_in;
assign faults[`SLEDFI_F_PAN_OC] = oc_latch_reg[0];
assign faults[`SLEDFI_F_TILT_OC] = oc_latch_reg[1];
assign faults[`SLEDFI_F_FOCUS_OC] = oc_latch_reg[2];
assign faults[`SLEDFI_F_PANEL_OC] = oc_latch_reg[3];
assign faults[`SLEDFI_F_HEATER_OC] = oc_latch_reg[4];
// Mask bits: 0,1 pan switches, 2,3 tilt switches in use for this product
assign faults[`SLEDFI_F_LIM_ERR] = |({tilt_lim_in, pan_lim_in} & ~lim_use_reg);
assign faults[`SLEDFI_F_DATUM] = datum_err_in;
assign faults[`SLEDFI_F_PROD] = (prod_type_reg == 4'h0) ||
	(prod_type_reg > `SLEDFI_PROD_TYPE_MAX);
assign faults[`SLEDFI_F_SUPPLY] = supply_bad_in;
assign any_fault = |faults;

// Overcurrent latches clear only at power-on reset; motor holds time out
always @(posedge ref_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		oc_latch_reg <= 5'h00;
		pan_hold_reg <= 32'h0;
		tilt_hold_reg <= 32'h0;
		focus_hold_reg <= 32'h0;
		pan_drv_en_out <= 1'b0;
		tilt_drv_en_out <= 1'b0;
		focus_drv_en_out <= 1'b0;
		panel_pwr_en_out <= 1'b0;
		heater_en_out <= 1'b0;
	end
	else
	begin
		oc_latch_reg <= oc_latch_reg |
			{heater_oc_in, panel_oc_in, focus_oc_in, tilt_oc_in, pan_oc_in};
		if (pan_oc_in)
			pan_hold_reg <= HOLD_CYC;
		else if (pan_hold_reg != 32'h0)
			pan_hold_reg <= pan_hold_reg - 32'h1;
		if (tilt_oc_in)
			tilt_hold_reg <= HOLD_CYC;
		else if (tilt_hold_reg != 32'h0)
			tilt_hold_reg <= tilt_hold_reg - 32'h1;
		if (focus_oc_in)
			focus_hold_reg <= HOLD_CYC;
		else if (focus_hold_reg != 32'h0)
			focus_hold_reg <= focus_hold_reg - 32'h1;
		pan_drv_en_out <= ~pan_oc_in & (pan_hold_reg == 32'h0);
		tilt_drv_en_out <= ~tilt_oc_in & (tilt_hold_reg == 32'h0);
		focus_drv_en_out <= ~focus_oc_in & (focus_hold_reg == 32'h0);
		panel_pwr_en_out <= ~panel_oc_in & ~oc_latch_reg[3];
		heater_en_out <= ~heater_oc_in & ~oc_latch_reg[4];
	end
end

// Activity tracking for the normal green display
always @(posedge ref_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		slow_reg <= 32'h0;
		slow_phase_reg <= 1'b1;
		blink_reg <= 32'h0;
		act_reg <= 32'h0;
		bus_cont_reg <= 1'b0;
		dmx_reg <= 32'h0;
	end
	else
	begin
		if (slow_reg == 32'h0)
		begin
			slow_reg <= SLOW_CYC - 32'h1;
			slow_phase_reg <= ~slow_phase_reg;
		end
		else
			slow_reg <= slow_reg - 32'h1;
		if (bus_rx_valid_in)
		begin
			blink_reg <= BLINK_CYC;
			act_reg <= ACT_CYC;
			// A second reception inside the window means the stream is continuous
			bus_cont_reg <= (act_reg != 32'h0);
		end
		else
		begin
			if (blink_reg != 32'h0)
				blink_reg <= blink_reg - 32'h1;
			if (act_reg != 32'h0)
				act_reg <= act_reg - 32'h1;
			else
				bus_cont_reg <= 1'b0;
		end
		if (dmx_rx_valid_in)
			dmx_reg <= DMX_CYC;
		else if (dmx_reg != 32'h0)
			dmx_reg <= dmx_reg - 32'h1;
	end
end

// Next active code above the current one, else the lowest active one
always @*
begin
	hit_above = 1'b0;
	hit_any = 1'b0;
	above_code = 4'h0;
	low_code = 4'h0;
	for (i = NF - 1; i >= 0; i = i - 1)
	begin
		if (faults[i])
		begin
			hit_any = 1'b1;
			low_code = i[3:0];
			if (i[3:0] > cur_reg)
			begin
				hit_above = 1'b1;
				above_code = i[3:0];
			end
		end
	end
	sel_code = hit_above ? above_code : low_code;
end

always @*
begin
	state_next = state_reg;
	cur_next = cur_reg;
	burst_start_next = 1'b0;
	burst_cnt_next = burst_cnt_reg;
	gap_next = gap_reg;
	green_next = 1'b0;
	red_next = 1'b0;
	case (state_reg)
		ST_VER:
		begin
			green_next = burst_led;
			if (burst_done)
				state_next = ST_NORM;
		end
		ST_NORM:
		begin
			if (any_fault)
				state_next = ST_PICK;
			else if (dmx_mode_reg)
				green_next = (dmx_reg != 32'h0) ? slow_phase_reg : 1'b1;
			else if (bus_cont_reg)
				green_next = slow_phase_reg;
			else
				green_next = (blink_reg == 32'h0);
		end
		ST_PICK:
		begin
			if (!hit_any)
				state_next = ST_NORM;
			else
			begin
				cur_next = sel_code;
				burst_cnt_next = sel_code + 4'h1;
				burst_start_next = 1'b1;
				state_next = ST_RUN;
			end
		end
		ST_RUN:
		begin
			red_next = burst_led;
			if (burst_done)
			begin
				gap_next = GAP_CYC;
				state_next = ST_GAP;
			end
		end
		ST_GAP:
		begin
			if (gap_reg == 32'h0)
				state_next = ST_PICK;
			else
				gap_next = gap_reg - 32'h1;
		end
		default: state_next = ST_NORM;
	endcase
end

// Version burst is armed straight out of reset
always @(posedge ref_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		state_reg <= ST_VER;
		cur_reg <= 4'hA;
		burst_start_reg <= 1'b1;
		burst_cnt_reg <= SW_VERSION;
		gap_reg <= 32'h0;
		led_green_out <= 1'b0;
		led_red_out <= 1'b0;
	end
	else
	begin
		state_reg <= state_next;
		cur_reg <= cur_next;
		burst_start_reg <= burst_start_next;
		burst_cnt_reg <= burst_cnt_next;
		gap_reg <= gap_next;
		led_green_out <= green_next;
		led_red_out <= red_next;
	end
end

sledfi_burst #(
	.ON_CYC(ON_CYC),
	.OFF_CYC(OFF_CYC)
) u_burst (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.start_in(burst_start_reg),
	.count_in(burst_cnt_reg),
	.led_out(burst_led),
	.done_out(burst_done)
);

endmodule

// *** testbench/sledfi_props_properties.sv ***
module sledfi_props (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire pan_oc_in,
	input wire tilt_oc_in,
	input wire focus_oc_in,
	input wire panel_oc_in,
	input wire heater_oc_in,
	input wire led_green_out,
	input wire led_red_out,
	input wire pan_drv_en_out,
	input wire tilt_drv_en_out,
	input wire focus_drv_en_out,
	input wire panel_pwr_en_out,
	input wire heater_en_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Figures follow the bench's short ON_CYC and OFF_CYC of four cycles
	sequence lit_four;
		led_red_out [*4] ##1 !led_red_out;
	endsequence
	sequence dark_four;
		!led_red_out [*4];
	endsequence
	a_red_flash_on: assert property ($rose(led_red_out) |-> lit_four)
		else $error("red flash on time wrong");
	a_red_flash_off: assert property ($fell(led_red_out) |-> dark_four)
		else $error("red flash off time wrong");
	a_no_green_fault: assert property (led_red_out |-> !led_green_out)
		else $error("green lit during red flash");
	a_pan_drive_off: assert property (pan_oc_in |=> !pan_drv_en_out [*8])
		else $error("pan drive not held off");
	a_tilt_drive_off: assert property (tilt_oc_in |=> !tilt_drv_en_out [*8])
		else $error("tilt drive not held off");
	a_focus_drive_off: assert property (focus_oc_in |=> !focus_drv_en_out [*8])
		else $error("focus drive not held off");
	a_panel_pwr_off: assert property (panel_oc_in |=> !panel_pwr_en_out [*8])
		else $error("panel supply not switched off");
	a_heater_off: assert property (heater_oc_in |=> !heater_en_out [*8])
		else $error("heater not switched off");
endmodule

// *** testbench/sledfi_panel_model.sv ***
// Limit switches, overcurrent and supply sensors, plus the red LED watcher
module sledfi_panel_model (
	input wire ref_clk_in,
	input wire [10:0] fault_in,
	input wire led_red_in,
	output logic [1:0] pan_lim_out,
	output logic [1:0] tilt_lim_out,
	output logic [4:0] oc_out,
	output logic datum_err_out,
	output logic supply_bad_out,
	output int red_rises,
	output int dark_run
);
	timeunit 1ns;
	timeprecision 100ps;
	logic red_q = 1'b0;
	assign pan_lim_out = {fault_in[0], fault_in[7]};
	// Second tilt switch closes only when both limit faults are asked for
	assign tilt_lim_out = {fault_in[1], fault_in[1] & fault_in[0]};
	assign oc_out = fault_in[6:2];
	assign datum_err_out = fault_in[8];
	assign supply_bad_out = fault_in[10];
	initial red_rises = 0;
	initial dark_run = 0;
	always @(posedge ref_clk_in)
	begin
		red_q <= led_red_in;
		if (led_red_in && !red_q)
			red_rises <= red_rises + 1;
		dark_run <= led_red_in ? 0 : dark_run + 1;
	end
endmodule

// *** testbench/sledfi_top_test.sv ***
module sledfi_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_in, rst_n_in, hsel, hwrite, bus_rx, dmx_rx, hready, hresp, green, red;
	logic [1:0] htrans, pan_lim, tilt_lim;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [4:0] oc, en;
	logic datum, supply;
	logic [2:0] hsize;
	logic [10:0] fv;
	int red_rises, dark_run, fail_count, n_tests, n;
	sledfi_top #(.ON_CYC(4), .OFF_CYC(4), .GAP_CYC(8), .SLOW_CYC(6),
		.BLINK_CYC(4), .ACT_CYC(20), .DMX_CYC(20), .HOLD_CYC(10)) uut (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.pan_lim_in(pan_lim), .tilt_lim_in(tilt_lim), .pan_oc_in(oc[0]), .tilt_oc_in(oc[1]),
		.focus_oc_in(oc[2]), .panel_oc_in(oc[3]), .heater_oc_in(oc[4]), .datum_err_in(datum),
		.supply_bad_in(supply), .bus_rx_valid_in(bus_rx), .dmx_rx_valid_in(dmx_rx),
		.led_green_out(green), .led_red_out(red), .pan_drv_en_out(en[0]),
		.tilt_drv_en_out(en[1]), .focus_drv_en_out(en[2]), .panel_pwr_en_out(en[3]),
		.heater_en_out(en[4]));
	sledfi_panel_model far (.ref_clk_in(ref_clk_in), .fault_in(fv), .led_red_in(red),
		.pan_lim_out(pan_lim), .tilt_lim_out(tilt_lim), .oc_out(oc), .datum_err_out(datum),
		.supply_bad_out(supply), .red_rises(red_rises), .dark_run(dark_run));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task guard(input int k);
		if (k >= 400)
		begin
			chk("wait bound", 0, k);
			summarize;
		end
	endtask
	task rdy;
		int k;
		k = 0;
		do
		begin
			@(posedge ref_clk_in);
			k++;
		end while (hready !== 1'b1 && k < 400);
		guard(k);
	endtask
	// Address phase, then data phase; read data taken at the edge ending it
	task xfer(input logic w, input logic [31:0] a, wd);
		@(posedge ref_clk_in);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		rdy;
		d = hrdata;
	endtask
	task rst;
		@(posedge ref_clk_in);
		fv <= 11'h000;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
	endtask
	task burst(output int cnt);
		int k, r0;
		k = 0;
		do
		begin
			@(negedge ref_clk_in);
			k++;
		end while (red !== 1'b1 && k < 400);
		r0 = red_rises;
		do
		begin
			@(negedge ref_clk_in);
			k++;
		end while (dark_run < 6 && k < 400);
		guard(k);
		cnt = red_rises - r0;
	endtask
	// Counts cycles in which the LED is not plain green over a window
	task watch(input int cyc, output int bad, output int falls);
		logic p;
		bad = 0;
		falls = 0;
		p = green;
		repeat (cyc)
		begin
			@(negedge ref_clk_in);
			bad += (green !== 1'b1 || red !== 1'b0);
			falls += (p === 1'b1 && green === 1'b0);
			p = green;
		end
	endtask
	task pulses(input logic dmx, input int cnt);
		repeat (cnt)
		begin
			@(posedge ref_clk_in);
			if (dmx)
				dmx_rx <= 1'b1;
			else
				bus_rx <= 1'b1;
			@(posedge ref_clk_in);
			dmx_rx <= 1'b0;
			bus_rx <= 1'b0;
			repeat (8) @(posedge ref_clk_in);
		end
	endtask
	task t_version;
		int bad, f;
		watch(60, bad, f);
		chk("version green cycles", 12, 60 - bad);
		chk("version flashes", 3, f);
		xfer(1'b0, 32'h00000008, 32'h0);
		chk("unset type fault", 1, d[9]);
		xfer(1'b0, 32'h00000040, 32'h0);
		chk("unmapped read", 0, d);
		chk("okay response", 0, hresp);
		xfer(1'b1, 32'h00000004, 32'h00000F01);
		repeat (200) @(posedge ref_clk_in);
		watch(20, bad, f);
		chk("steady green", 0, bad);
		$display("version test done");
	endtask
	task t_bus;
		int bad, f;
		fork
			pulses(1'b0, 1);
			watch(12, bad, f);
		join
		chk("blink length", 4, bad);
		fork
			pulses(1'b0, 10);
			watch(100, bad, f);
		join
		// Ten plain blinks would give ten falls; the slow flash gives fewer
		chk("bus activity", 1, f > 3 && f < 10);
		repeat (40) @(posedge ref_clk_in);
		watch(20, bad, f);
		chk("bus idle green", 0, bad);
		xfer(1'b0, 32'h0000000C, 32'h0);
		chk("status version", 3, d[19:16]);
		chk("status state", 2, d[4:0]);
		chk("status green", 1, d[5]);
		chk("status enables", 31, d[11:7]);
		$display("bus test done");
	endtask
	task t_dmx;
		int bad, f;
		xfer(1'b1, 32'h00000000, 32'h00000001);
		xfer(1'b0, 32'h00000000, 32'h0);
		chk("dmx mode", 1, d[0]);
		fork
			pulses(1'b1, 10);
			watch(100, bad, f);
		join
		chk("dmx slow flash", 1, f > 3);
		repeat (40) @(posedge ref_clk_in);
		watch(20, bad, f);
		chk("dmx idle green", 0, bad);
		xfer(1'b1, 32'h00000000, 32'h00000000);
		$display("dmx test done");
	endtask
	task t_codes;
		for (int i = 0; i < 11; i++)
		begin
			rst;
			xfer(1'b1, 32'h00000004, i == 9 ? 32'h0 : i == 7 ? 32'h00000E01 : 32'h00000F01);
			fv <= 11'h001 << i;
			burst(n);
			if (i == 7)
			begin
				chk("pan switch", 1, n);
				burst(n);
			end
			chk("flash count", i + 1, n);
			xfer(1'b0, 32'h00000008, 32'h0);
			chk("fault flag", 1, d[i]);
			if (i >= 2 && i <= 6)
			begin
				chk("enable off", 0, en[i - 2]);
				fv <= 11'h000;
				burst(n);
				chk("latched count", i + 1, n);
				chk("enable after", i <= 4, en[i - 2]);
			end
		end
		$display("code test done");
	endtask
	task t_multi;
		int bad, f;
		rst;
		xfer(1'b1, 32'h00000004, 32'h00000F01);
		fv <= 11'h003;
		burst(n);
		chk("first burst", 1, n);
		burst(n);
		chk("second burst", 2, n);
		burst(n);
		chk("wrapped burst", 1, n);
		fv <= 11'h000;
		repeat (60) @(posedge ref_clk_in);
		watch(20, bad, f);
		chk("limits clear", 0, bad);
		$display("multi fault test done");
	endtask
	initial
	begin
		fail_count = 0;
		n_tests = 0;
		rst_n_in = 1'b0;
		{hsel, hwrite, bus_rx, dmx_rx} = 4'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		fv = 11'h000;
		repeat (16) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		t_version;
		t_bus;
		t_dmx;
		t_codes;
		t_multi;
		summarize;
	end
endmodule

bind sledfi_top sledfi_props u_props (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.pan_oc_in(pan_oc_in), .tilt_oc_in(tilt_oc_in), .focus_oc_in(focus_oc_in),
	.panel_oc_in(panel_oc_in), .heater_oc_in(heater_oc_in), .led_green_out(led_green_out),
	.led_red_out(led_red_out), .pan_drv_en_out(pan_drv_en_out),
	.tilt_drv_en_out(tilt_drv_en_out), .focus_drv_en_out(focus_drv_en_out),
	.panel_pwr_en_out(panel_pwr_en_out), .heater_en_out(heater_en_out));
